// ### aopc_pkg.sv
// Purpose : Shared constants and types for the protection and monitor config bank
// Assumes : 100 MHz system clock, APB register access with 32-bit data
// Notes   : Register data is 16 bits wide and sits in the low half of the word

package aopc_pkg;

   // ------------------------------------------------------------
   // Bus and register map
   // ------------------------------------------------------------
   localparam int unsigned ADDR_W          = 12;
   localparam int unsigned DATA_W          = 32;
   localparam int unsigned REG_W           = 16;
   localparam logic [11:0] CFG_OFFSET      = 12'h000;
   localparam logic [11:0] STATUS_OFFSET   = 12'h004;

   // ------------------------------------------------------------
   // Configuration field positions
   // ------------------------------------------------------------
   localparam int unsigned BIT_OT_ONE      = 15;
   localparam int unsigned BIT_OT_THREE    = 14;
   localparam int unsigned BIT_OT_FIVE     = 13;
   localparam int unsigned BIT_OC_TWO      = 12;
   localparam int unsigned BIT_OC_FOUR     = 11;
   localparam int unsigned BIT_OC_SIX      = 10;
   localparam int unsigned RATE_MSB        = 9;
   localparam int unsigned RATE_LSB        = 8;
   localparam int unsigned BIT_RESERVED    = 7;
   localparam int unsigned BIT_RT_DIE      = 6;
   localparam int unsigned BIT_RT_SIX      = 5;
   localparam int unsigned BIT_RT_FOUR     = 4;
   localparam int unsigned BIT_RT_TWO      = 3;
   localparam int unsigned BIT_RT_FIVE     = 2;
   localparam int unsigned BIT_RT_THREE    = 1;
   localparam int unsigned BIT_RT_ONE      = 0;
   localparam int unsigned ROUTE_W         = 7;

   // Value after reset: over-current on inputs two and four enabled
   localparam logic [15:0] CFG_RESET       = 16'h1800;

   // ------------------------------------------------------------
   // Status field positions
   // ------------------------------------------------------------
   localparam int unsigned ST_SRC_LSB      = 0;
   localparam int unsigned ST_MULTI        = 3;
   localparam int unsigned ST_PHASE        = 4;
   localparam int unsigned ST_PROT_LSB     = 8;

   // ------------------------------------------------------------
   // Monitor pin rates
   // ------------------------------------------------------------
   localparam int unsigned CLK_HZ          = 100_000_000;
   localparam int unsigned RATE0_HZ        = 13_900;
   localparam int unsigned RATE1_HZ        = 27_800;
   localparam int unsigned RATE2_HZ        = 55_700;
   localparam int unsigned RATE3_HZ        = 111_400;
   localparam int unsigned RATE0_CYCLES    = CLK_HZ / RATE0_HZ;
   localparam int unsigned RATE1_CYCLES    = CLK_HZ / RATE1_HZ;
   localparam int unsigned RATE2_CYCLES    = CLK_HZ / RATE2_HZ;
   localparam int unsigned RATE3_CYCLES    = CLK_HZ / RATE3_HZ;
   localparam int unsigned RATE_CNT_W      = 16;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef struct packed {
      logic ot_one;
      logic ot_three;
      logic ot_five;
      logic oc_two;
      logic oc_four;
      logic oc_six;
   } aopc_prot_en_t;

   typedef enum logic [2:0] {
      SRC_NONE,
      SRC_IN_ONE,
      SRC_IN_THREE,
      SRC_IN_FIVE,
      SRC_IN_TWO,
      SRC_IN_FOUR,
      SRC_IN_SIX,
      SRC_DIE_TEMP
   } aopc_src_t;

   typedef struct packed {
      aopc_src_t  source;
      logic [1:0] rate_sel;
      logic       tick;
      logic       phase;
   } aopc_monitor_t;

endpackage : aopc_pkg

// ### aopc_rate_gen.sv
// Purpose : Period generator for the monitor pin rate
// Assumes : Four selectable periods given in system clock cycles
// Notes   : Counter restarts whenever the selected rate changes

`timescale 1ns/10ps
`default_nettype none

module aopc_rate_gen #(
   parameter int unsigned CNT_W = 16,
   parameter int unsigned P0    = 7194,
   parameter int unsigned P1    = 3597,
   parameter int unsigned P2    = 1795,
   parameter int unsigned P3    = 897
) (
   // Clock and reset
   input  wire logic             sys_clk,
   input  wire logic             rstn,
   // Rate choice
   input  wire logic [1:0]       rate_sel,
   // Period outputs
   output var  logic             tick,
   output var  logic             phase
);

   // ------------------------------------------------------------
   // Elaboration checks
   // ------------------------------------------------------------
   initial
   begin
      if (P0 < 2 || P1 < 2 || P2 < 2 || P3 < 2 || P0 >= (1 << CNT_W) ||
          P1 >= (1 << CNT_W) || P2 >= (1 << CNT_W) || P3 >= (1 << CNT_W))
      begin
         $error("aopc_rate_gen: periods must be at least 2 and fit CNT_W");
      end
   end

   logic [CNT_W-1:0] count_reg;
   logic [CNT_W-1:0] period_m1;
   logic [1:0]       sel_reg;

   // Period minus one for the selected rate
   always_comb
   begin
      unique case (rate_sel)
         2'h0:    period_m1 = CNT_W'(P0 - 1);
         2'h1:    period_m1 = CNT_W'(P1 - 1);
         2'h2:    period_m1 = CNT_W'(P2 - 1);
         default: period_m1 = CNT_W'(P3 - 1);
      endcase
   end

   // Period counter; a rate change restarts it to avoid a runt period
   always_ff @(posedge sys_clk)
   begin
      if (!rstn || sel_reg != rate_sel || count_reg >= period_m1)
      begin
         count_reg <= '0;
      end
      else
      begin
         count_reg <= count_reg + 1'b1;
      end
   end

   // Selection seen last cycle
   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
         sel_reg <= 2'h0;
      else
         sel_reg <= rate_sel;
   end

   // One-cycle tick at the end of each period, phase high for the first (period - 1) / 2 counts, rounded down
   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
      begin
         tick  <= 1'b0;
         phase <= 1'b0;
      end
      else
      begin
         tick  <= (sel_reg == rate_sel) && (count_reg >= period_m1);
         phase <= (count_reg < (period_m1 >> 1));
      end
   end

endmodule : aopc_rate_gen

`default_nettype wire

// ### aopc_config_bank.sv
// Purpose : APB configuration bank for power FET protection and monitor pin routing
// Assumes : Single 100 MHz clock, synchronous active-low reset, zero-wait APB
// Notes   : Consumers of the enables and routing live outside this block
//
// Contract
// - Bit 15 enables over-temperature protection from input one, reset 0.
// - Bit 14 enables over-temperature protection from input three, reset 0.
// - Bit 13 enables over-temperature protection from input five, reset 0.
// - Bit 12 enables over-current protection from input two, reset 1.
// - Bit 11 enables over-current protection from input four, reset 1.
// - Bit 10 enables over-current protection from input six, reset 0.
// - Bit 6 routes the die temperature to the monitor pin, reset 0.
// - Bit 5 routes input six to the monitor pin, reset 0.
// - Bit 4 routes input four to the monitor pin, reset 0.
// - Bit 3 routes input two to the monitor pin, reset 0.
// - Bit 2 routes input five to the monitor pin, reset 0.
// - Bit 1 routes input three to the monitor pin, reset 0.
// - Bit 0 routes input one to the monitor pin, reset 0.
//
// Chosen here: the APB interface to the registers and the register offsets.

`timescale 1ns/10ps
`default_nettype none

module aopc_config_bank
   import aopc_pkg::*;
#(
   parameter int unsigned RATE0_PERIOD = aopc_pkg::RATE0_CYCLES,
   parameter int unsigned RATE1_PERIOD = aopc_pkg::RATE1_CYCLES,
   parameter int unsigned RATE2_PERIOD = aopc_pkg::RATE2_CYCLES,
   parameter int unsigned RATE3_PERIOD = aopc_pkg::RATE3_CYCLES
) (
   // Clock and reset
   input  wire logic                        sys_clk,
   input  wire logic                        rstn,
   // APB slave
   input  wire logic [aopc_pkg::ADDR_W-1:0] paddr,
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [aopc_pkg::DATA_W-1:0] pwdata,
   input  wire logic [3:0]                  pstrb,
   output var  logic [aopc_pkg::DATA_W-1:0] prdata,
   output var  logic                        pready,
   output var  logic                        pslverr,
   // Protection enables to the comparators
   output var  aopc_pkg::aopc_prot_en_t     prot_en,
   // Monitor pin source, rate and timing
   output var  aopc_pkg::aopc_monitor_t     monitor,
   // Routing fault seen: more than one source requested
   output var  logic                        route_conflict,
   // Pulse when software changes the configuration
   output var  logic                        cfg_changed
);

   // ------------------------------------------------------------
   // Elaboration checks
   // ------------------------------------------------------------
   initial
   begin
      if (RATE0_PERIOD < 2 || RATE1_PERIOD < 2 || RATE2_PERIOD < 2 || RATE3_PERIOD < 2)
      begin
         $error("aopc_config_bank: rate periods must be at least 2 cycles");
      end
      if (REG_W > DATA_W || ROUTE_W > REG_W)
      begin
         $error("aopc_config_bank: register must fit the bus word");
      end
   end

   // ------------------------------------------------------------
   // Helper functions
   // ------------------------------------------------------------

   // At most seven bits can be set, so three bits of count suffice
   // Number of routing bits set
   function automatic logic [2:0] route_count(input logic [ROUTE_W-1:0] r);
      logic [2:0] n;
      n = 3'h0;
      for (int i = 0; i < ROUTE_W; i++)
      begin
         n = n + {2'b00, r[i]};
      end
      return n;
   endfunction : route_count

   // The if chain is no priority scheme: it only runs with exactly one bit set
   // Source picked by a single routing bit; none when zero or several are set
   function automatic aopc_src_t route_decode(input logic [REG_W-1:0] c);
      aopc_src_t s;
      s = SRC_NONE;
      if (route_count(c[ROUTE_W-1:0]) == 3'h1)
      begin
         if (c[BIT_RT_DIE])        s = SRC_DIE_TEMP;
         else if (c[BIT_RT_SIX])   s = SRC_IN_SIX;
         else if (c[BIT_RT_FOUR])  s = SRC_IN_FOUR;
         else if (c[BIT_RT_TWO])   s = SRC_IN_TWO;
         else if (c[BIT_RT_FIVE])  s = SRC_IN_FIVE;
         else if (c[BIT_RT_THREE]) s = SRC_IN_THREE;
         else                      s = SRC_IN_ONE;
      end
      return s;
   endfunction : route_decode

   // Lanes 2 and 3 carry nothing; their strobes are ignored
   // Byte-lane merge of the low half-word
   function automatic logic [REG_W-1:0] lane_merge(input logic [REG_W-1:0]  old,
                                                   input logic [DATA_W-1:0] wd,
                                                   input logic [3:0]        st);
      logic [REG_W-1:0] m;
      m = old;
      if (st[0]) m[7:0]  = wd[7:0];
      if (st[1]) m[15:8] = wd[15:8];
      return m;
   endfunction : lane_merge

   // ------------------------------------------------------------
   // Bus phase decode
   // ------------------------------------------------------------
   logic             setup_phase;
   logic             access_phase;
   logic             hit_cfg;
   logic             hit_status;
   logic             mapped;
   logic             cfg_write;

   // Only the two word addresses decode; all other address bits must be zero
   // Word-aligned decode; misaligned addresses count as unmapped
   assign setup_phase  = psel && !penable;
   assign access_phase = psel && penable;
   assign hit_cfg      = (paddr == CFG_OFFSET);
   assign hit_status   = (paddr == STATUS_OFFSET);
   assign mapped       = hit_cfg || hit_status;
   assign cfg_write    = access_phase && pwrite && hit_cfg;

   // Read data is ready from the setup edge, so there is no reason to stall
   // Zero-wait slave: every access phase completes at once
   assign pready = 1'b1;

   // ------------------------------------------------------------
   // Configuration register
   // ------------------------------------------------------------
   logic [REG_W-1:0] cfg_reg;
   logic [REG_W-1:0] cfg_next;

   // Write data merged by lane; reserved bit 7 is stored like any other
   always_comb
   begin
      cfg_next = cfg_reg;
      if (cfg_write)
      begin
         cfg_next = lane_merge(cfg_reg, pwdata, pstrb);
      end
   end

   // Stored value, reset leaves only inputs two and four protected
   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
         cfg_reg <= CFG_RESET;
      else
         cfg_reg <= cfg_next;
   end

   // Rewriting the same value gives no pulse, so consumers see only real moves
   // Change pulse only when the stored value actually moves
   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
         cfg_changed <= 1'b0;
      else
         cfg_changed <= (cfg_next != cfg_reg);
   end

   // ------------------------------------------------------------
   // Protection enables
   // ------------------------------------------------------------

   // One flop behind each enable, so the comparators never see a glitch
   // Straight from the register bits; reserved bit 7 takes no part
   always_comb
   begin
      prot_en.ot_one   = cfg_reg[BIT_OT_ONE];
      prot_en.ot_three = cfg_reg[BIT_OT_THREE];
      prot_en.ot_five  = cfg_reg[BIT_OT_FIVE];
      prot_en.oc_two   = cfg_reg[BIT_OC_TWO];
      prot_en.oc_four  = cfg_reg[BIT_OC_FOUR];
      prot_en.oc_six   = cfg_reg[BIT_OC_SIX];
   end

   // ------------------------------------------------------------
   // Monitor pin routing
   // ------------------------------------------------------------
   aopc_src_t        src_reg;
   logic             conflict_reg;

   // Limitation: a conflicting request silences the pin rather than picking one
   // Registered source; a conflicting request routes nothing to the pin
   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
         src_reg <= SRC_NONE;
      else
         src_reg <= route_decode(cfg_reg);
   end

   // One cycle behind the register, in step with the source
   // Flag software that broke the one-source convention
   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
         conflict_reg <= 1'b0;
      else
         conflict_reg <= (route_count(cfg_reg[ROUTE_W-1:0]) > 3'h1);
   end

   assign route_conflict = conflict_reg;

   // ------------------------------------------------------------
   // Monitor pin rate
   // ------------------------------------------------------------
   logic             rate_tick;
   logic             rate_phase;

   // Trade-off: periods are whole cycles, truncated, so each rate runs a bit fast
   // Period generator follows the rate field directly
   aopc_rate_gen #(
      .CNT_W    (RATE_CNT_W),
      .P0       (RATE0_PERIOD),
      .P1       (RATE1_PERIOD),
      .P2       (RATE2_PERIOD),
      .P3       (RATE3_PERIOD)
   ) u_rate_gen (
      .sys_clk  (sys_clk),
      .rstn     (rstn),
      .rate_sel (cfg_reg[RATE_MSB:RATE_LSB]),
      .tick     (rate_tick),
      .phase    (rate_phase)
   );

   // Monitor bundle; timing runs even with no source so the pin keeps its rate
   always_comb
   begin
      monitor.source   = src_reg;
      monitor.rate_sel = cfg_reg[RATE_MSB:RATE_LSB];
      monitor.tick     = rate_tick;
      monitor.phase    = rate_phase;
   end

   // ------------------------------------------------------------
   // Status word
   // ------------------------------------------------------------
   logic [REG_W-1:0] status_word;

   // Phase bit is live and may differ between two reads
   // Live view of the block: source, conflict, pin phase and enables
   always_comb
   begin
      status_word                              = '0;
      status_word[ST_SRC_LSB +: 3]             = src_reg;
      status_word[ST_MULTI]                    = conflict_reg;
      status_word[ST_PHASE]                    = rate_phase;
      status_word[ST_PROT_LSB +: 6]            = prot_en;
   end

   // ------------------------------------------------------------
   // Read data and error response
   // ------------------------------------------------------------

   // Upper half-word always reads as zero
   // Captured in setup so prdata comes from a flop in the access phase
   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
      begin
         prdata <= '0;
      end
      else if (setup_phase && !pwrite)
      begin
         if (hit_cfg)
            prdata <= {16'h0000, cfg_reg};
         else if (hit_status)
            prdata <= {16'h0000, status_word};
         else
            prdata <= '0;
      end
   end

   // A status write is refused loudly rather than dropped in silence
   // Unmapped addresses and status writes answer with an error
   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
         pslverr <= 1'b0;
      else if (setup_phase)
         pslverr <= !mapped || (pwrite && hit_status);
      else if (!psel)
         pslverr <= 1'b0;
   end

endmodule : aopc_config_bank

`default_nettype wire

// ### aopc_config_bank_assertions.sv
// Purpose : Port-level checker for the protection and monitor config bank
// Assumes : One clock domain, synchronous active-low reset
// Notes   : Period parameters must match the checked instance
`timescale 1ns/10ps
`default_nettype none
module aopc_config_bank_assertions
   import aopc_pkg::*;
#(
   parameter int unsigned RATE0_PERIOD = aopc_pkg::RATE0_CYCLES,
   parameter int unsigned RATE1_PERIOD = aopc_pkg::RATE1_CYCLES,
   parameter int unsigned RATE2_PERIOD = aopc_pkg::RATE2_CYCLES,
   parameter int unsigned RATE3_PERIOD = aopc_pkg::RATE3_CYCLES
) (
   // Clock and reset
   input wire logic                        sys_clk,
   input wire logic                        rstn,
   // APB
   input wire logic [aopc_pkg::ADDR_W-1:0] paddr,
   input wire logic                        psel,
   input wire logic                        penable,
   input wire logic                        pwrite,
   input wire logic [aopc_pkg::DATA_W-1:0] pwdata,
   input wire logic [3:0]                  pstrb,
   input wire logic [aopc_pkg::DATA_W-1:0] prdata,
   input wire logic                        pready,
   input wire logic                        pslverr,
   // Block outputs
   input wire aopc_pkg::aopc_prot_en_t     prot_en,
   input wire aopc_pkg::aopc_monitor_t     monitor,
   input wire logic                        route_conflict,
   input wire logic                        cfg_changed
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);

   // ---------------------------------------------------------
   // Helper logic
   // ---------------------------------------------------------
   logic        wr_cfg;
   logic [15:0] gap_reg;
   logic        armed_reg;
   logic [1:0]  rate_prev_reg;
   int unsigned per;

   // Decode of a completing configuration write
   assign wr_cfg = psel && penable && pwrite && pready && paddr == CFG_OFFSET;
   assign per = monitor.rate_sel == 2'h0 ? RATE0_PERIOD : monitor.rate_sel == 2'h1 ?
                RATE1_PERIOD : monitor.rate_sel == 2'h2 ? RATE2_PERIOD : RATE3_PERIOD;

   // Tick spacing; disarmed on a rate change since the counter restarts
   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
      begin
         gap_reg       <= 16'h0;
         armed_reg     <= 1'b0;
         rate_prev_reg <= 2'h0;
      end
      else
      begin
         gap_reg       <= monitor.tick ? 16'h1 : gap_reg + 16'h1;
         armed_reg     <= monitor.rate_sel != rate_prev_reg ? 1'b0 :
                          monitor.tick ? 1'b1 : armed_reg;
         rate_prev_reg <= monitor.rate_sel;
      end
   end

   function automatic aopc_src_t exp_src(input logic [6:0] r);
      case (r)
         7'h01:   return SRC_IN_ONE;
         7'h02:   return SRC_IN_THREE;
         7'h04:   return SRC_IN_FIVE;
         7'h08:   return SRC_IN_TWO;
         7'h10:   return SRC_IN_FOUR;
         7'h20:   return SRC_IN_SIX;
         7'h40:   return SRC_DIE_TEMP;
         default: return SRC_NONE;
      endcase
   endfunction : exp_src

   // ---------------------------------------------------------
   // Properties
   // ---------------------------------------------------------
   property p_prot;
      wr_cfg && pstrb[1] |=> prot_en == $past(pwdata[15:10]);
   endproperty
   a_prot: assert property (p_prot) else $error("enables differ from write");

   property p_rate;
      wr_cfg && pstrb[1] |=> monitor.rate_sel == $past(pwdata[9:8]);
   endproperty
   a_rate: assert property (p_rate) else $error("rate differs from write");

   property p_src;
      wr_cfg && pstrb[0] |=> ##1 monitor.source == exp_src($past(pwdata[6:0], 2));
   endproperty
   a_src: assert property (p_src) else $error("wrong monitor source");

   property p_conflict;
      wr_cfg && pstrb[0] |=> ##1 route_conflict == ($countones($past(pwdata[6:0], 2)) > 1);
   endproperty
   a_conflict: assert property (p_conflict) else $error("conflict flag wrong");

   property p_hold;
      !wr_cfg |=> $stable(prot_en) && $stable(monitor.rate_sel);
   endproperty
   a_hold: assert property (p_hold) else $error("config moved without write");

   property p_rst;
      $rose(rstn) |-> prot_en == 6'h06 && monitor.source == SRC_NONE && !cfg_changed;
   endproperty
   a_rst: assert property (p_rst) else $error("bad value after reset");

   property p_tick;
      armed_reg && monitor.rate_sel == rate_prev_reg |->
         gap_reg <= per && monitor.tick == (gap_reg == per);
   endproperty
   a_tick: assert property (p_tick) else $error("tick period wrong");

   property p_phase;
      armed_reg && monitor.rate_sel == rate_prev_reg |->
         monitor.phase == (gap_reg <= (per - 1) / 2);
   endproperty
   a_phase: assert property (p_phase) else $error("monitor phase wrong");

   property p_err;
      psel && penable && paddr != CFG_OFFSET && (pwrite || paddr != STATUS_OFFSET) |-> pslverr;
   endproperty
   a_err: assert property (p_err) else $error("no error on bad access");

   property p_ready;
      psel && penable |-> pready;
   endproperty
   a_ready: assert property (p_ready) else $error("wait state inserted");

   c_wr: cover property (wr_cfg && pstrb[0]);
   c_tick: cover property (armed_reg && monitor.tick);
   c_conf: cover property (route_conflict);
endmodule : aopc_config_bank_assertions
`default_nettype wire

// ### aopc_config_bank_tb.sv
// Purpose : Self-checking bench for the protection and monitor config bank
// Assumes : Zero-wait APB slave, short rate periods for simulation
// Notes   : At least one idle cycle between transfers
`timescale 1ns/10ps
`default_nettype none
module aopc_config_bank_tb;
   import aopc_pkg::*;
   localparam int unsigned PER [4] = '{8, 6, 4, 2};
   logic          sys_clk, rstn, psel, penable, pwrite, pready, pslverr, err;
   logic          route_conflict, cfg_changed;
   logic [11:0]   paddr;
   logic [31:0]   pwdata, prdata, rd;
   logic [3:0]    pstrb;
   aopc_prot_en_t prot_en;
   aopc_monitor_t monitor;
   int            mismatches, compares, n, p;
   aopc_src_t     tab [7] = '{SRC_IN_ONE, SRC_IN_THREE, SRC_IN_FIVE, SRC_IN_TWO,
                              SRC_IN_FOUR, SRC_IN_SIX, SRC_DIE_TEMP};

   aopc_config_bank #(.RATE0_PERIOD(PER[0]), .RATE1_PERIOD(PER[1]),
      .RATE2_PERIOD(PER[2]), .RATE3_PERIOD(PER[3])) u_dut (.sys_clk, .rstn,
      .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .prdata, .pready,
      .pslverr, .prot_en, .monitor, .route_conflict, .cfg_changed);

   // 100 MHz clock
   always #5 sys_clk = ~sys_clk;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         mismatches++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // One APB transfer; waits on pready, watchdog cuts a hang
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s);
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      pstrb <= s;
      @(posedge sys_clk);
      penable <= 1'b1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // Write then let routing settle two cycles later
   task automatic wr(input logic [15:0] v);
      apb(1'b1, CFG_OFFSET, {16'h0, v}, 4'h3);
      repeat (2) @(posedge sys_clk);
      #1;
   endtask : wr

   task automatic rcfg;
      apb(1'b0, CFG_OFFSET, 32'h0, 4'h0);
   endtask : rcfg

   task automatic test_done;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : test_done

   // Watchdog
   initial
   begin
      repeat (20000) @(posedge sys_clk);
      mismatches++;
      test_done;
   end

   initial
   begin
      {sys_clk, rstn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
      repeat (20) @(posedge sys_clk);
      rstn <= 1'b1;
      rcfg;
      chk(rd, 32'h1800);
      chk(prot_en, 6'h06);
      apb(1'b0, STATUS_OFFSET, 32'h0, 4'h0);
      chk(rd & ~32'h10, 32'h0600);
      // Each routing bit alone
      for (n = 0; n < 7; n++)
      begin
         wr(16'h1800 | (16'h1 << n));
         chk(monitor.source, tab[n]);
         chk(route_conflict, 1'b0);
      end
      // Each protection enable alone, with read-back
      for (n = 0; n < 6; n++)
      begin
         wr(16'h0400 << n);
         chk(prot_en, 6'h01 << n);
         rcfg;
         chk(rd, 32'h0400 << n);
      end
      // Every rate, period measured between two ticks
      for (n = 0; n < 4; n++)
      begin
         wr(16'(n) << 8);
         chk(monitor.rate_sel, n);
         @(posedge sys_clk iff monitor.tick === 1'b1);
         p = 0;
         do
         begin
            @(posedge sys_clk);
            p++;
         end
         while (monitor.tick !== 1'b1 && p < 100);
         chk(p, PER[n]);
      end
      // Two sources at once
      wr(16'h0005);
      chk(monitor.source, SRC_NONE);
      chk(route_conflict, 1'b1);
      // Reserved bit stores only
      wr(16'h0080);
      chk({prot_en, monitor.source, route_conflict}, 32'h0);
      rcfg;
      chk(rd, 32'h0080);
      // Byte lanes
      wr(16'h1800);
      apb(1'b1, CFG_OFFSET, 32'hffff_ffff, 4'h1);
      #1 chk(cfg_changed, 1'b1);
      apb(1'b1, CFG_OFFSET, 32'h0, 4'h2);
      apb(1'b1, CFG_OFFSET, 32'h0, 4'h2);
      #1 chk(cfg_changed, 1'b0);
      rcfg;
      chk(rd, 32'h00ff);
      // Refused accesses
      apb(1'b1, STATUS_OFFSET, 32'hffff, 4'hf);
      chk(err, 1'b1);
      apb(1'b0, 12'h008, 32'h0, 4'h0);
      chk(err, 1'b1);
      chk(rd, 32'h0);
      apb(1'b0, 12'h002, 32'h0, 4'h0);
      chk(err, 1'b1);
      rcfg;
      chk(err, 1'b0);
      chk(rd, 32'h00ff);
      // Reset in mid-run
      @(posedge sys_clk);
      rstn <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rstn <= 1'b1;
      rcfg;
      chk(rd, 32'h1800);
      test_done;
   end
endmodule : aopc_config_bank_tb

bind aopc_config_bank aopc_config_bank_assertions #(.RATE0_PERIOD(RATE0_PERIOD),
   .RATE1_PERIOD(RATE1_PERIOD), .RATE2_PERIOD(RATE2_PERIOD),
   .RATE3_PERIOD(RATE3_PERIOD)) u_chk (.sys_clk, .rstn, .paddr, .psel, .penable,
   .pwrite, .pwdata, .pstrb, .prdata, .pready, .pslverr, .prot_en, .monitor,
   .route_conflict, .cfg_changed);
`default_nettype wire
